// ### inc/gpfgh_pkg.sv
// gpfgh_pkg: register map, reset values, selector codes, bus states and pin helpers
// for the three-port pin multiplexer; shared by the bus front end and the port core.
package gpfgh_pkg;

   // port widths
   localparam int F_W = 8;
   localparam int G_W = 16;
   localparam int H_W = 11;

   // register byte addresses (aligned 32-bit words)
   localparam logic [31:0] ADDR_F_CFG = 32'h5600_0050;
   localparam logic [31:0] ADDR_F_DAT = 32'h5600_0054;
   localparam logic [31:0] ADDR_F_PUD = 32'h5600_0058;
   localparam logic [31:0] ADDR_G_CFG = 32'h5600_0060;
   localparam logic [31:0] ADDR_G_DAT = 32'h5600_0064;
   localparam logic [31:0] ADDR_G_PUD = 32'h5600_0068;
   localparam logic [31:0] ADDR_H_CFG = 32'h5600_0070;
   localparam logic [31:0] ADDR_H_DAT = 32'h5600_0074;
   localparam logic [31:0] ADDR_H_PUD = 32'h5600_0078;

   // reset values
   localparam logic [2*F_W-1:0] F_CFG_RST = 16'h0000;
   localparam logic [2*G_W-1:0] G_CFG_RST = 32'h0000_0000;
   localparam logic [2*H_W-1:0] H_CFG_RST = 22'h00_0000;
   localparam logic [F_W-1:0]   F_PUD_RST = 8'h00;
   localparam logic [G_W-1:0]   G_PUD_RST = 16'hfc00;
   localparam logic [H_W-1:0]   H_PUD_RST = 11'h000;

   // selector codes
   localparam logic [1:0] SEL_IN   = 2'h0;
   localparam logic [1:0] SEL_OUT  = 2'h1;
   localparam logic [1:0] SEL_ALT2 = 2'h2;
   localparam logic [1:0] SEL_ALT3 = 2'h3;

   // pins where code three is a real function; elsewhere it is reserved
   localparam logic [G_W-1:0] G_ALT3_MASK = 16'h0efc;
   localparam logic [H_W-1:0] H_ALT3_MASK = 11'h0c0;
   // serial channel one flow control pins on both ports
   localparam int G_RTS_PIN = 9;
   localparam int G_CTS_PIN = 10;
   localparam int H_RTS_PIN = 6;
   localparam int H_CTS_PIN = 7;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HRESP_OKAY    = 2'h0;

   typedef enum logic [1:0] {
      FE_IDLE  = 2'b00,
      FE_WRITE = 2'b01,
      FE_READ  = 2'b10
   } gpfgh_fe_state_t;

   // pad drive {oe, out} for one pin; reserved codes fall back to input
   function automatic logic [1:0] pinDrive(input logic [1:0] sel, input logic dat,
                                           input logic a2o, input logic a2e,
                                           input logic a3ok, input logic a3o, input logic a3e);
      logic [1:0] drv;
      drv = 2'b00;
      if (sel == SEL_OUT) drv = {1'b1, dat};
      else if (sel == SEL_ALT2) drv = {a2e, a2o};
      else if (sel == SEL_ALT3 && a3ok) drv = {a3e, a3o};
      return drv;
   endfunction

   // read-back bit: pad level on input (and reserved), stored bit otherwise
   function automatic logic pinRead(input logic [1:0] sel, input logic a3ok,
                                    input logic pad, input logic dat);
      logic isIn;
      isIn = (sel == SEL_IN) || (sel == SEL_ALT3 && !a3ok);
      return isIn ? pad : dat;
   endfunction

endpackage

// ### inc/gpfgh_regs_if.sv
// gpfgh_regs_if: register access path between the bus front end and the port core.
// assumes one clock; wrEn is a one-cycle strobe, rdData is combinational from the core.
`timescale 1ns/1ns
interface gpfgh_regs_if;
   logic        wrEn;     // write strobe in the data phase
   logic [31:0] addr;     // latched byte address of the transfer
   logic [31:0] wrData;   // write data (hwdata)
   logic [31:0] rdData;   // read-back word for addr
   logic        hit;      // addr is a mapped register

   modport fe   (output wrEn, output addr, output wrData, input rdData, input hit);
   modport regs (input wrEn, input addr, input wrData, output rdData, output hit);
endinterface

// ### rtl/gpfgh_ahb_front.sv
// gpfgh_ahb_front: AHB-Lite slave front end; zero-wait writes, one wait state on reads.
// assumes single word transfers; the core answers rdData for the latched address.
`timescale 1ns/1ns
module gpfgh_ahb_front
   import gpfgh_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   gpfgh_regs_if.fe         bus
);

   gpfgh_fe_state_t state;
   gpfgh_fe_state_t next_state;
   logic [31:0]     addrQ;
   wire             accept = hsel && htrans[1] && hready;
   wire             sizeWord = (hsize == 3'h2);

   // only word writes reach the registers; narrower ones complete harmlessly
   assign bus.wrEn   = (state == FE_WRITE);
   assign bus.addr   = addrQ;
   assign bus.wrData = hwdata;
   assign next_state = accept ? (hwrite ? (sizeWord ? FE_WRITE : FE_IDLE) : FE_READ) : FE_IDLE;

   // address phase capture and state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= FE_IDLE;
         addrQ <= 32'h0000_0000;
      end else begin
         state <= next_state;
         if (accept) addrQ <= haddr;
      end
   end

   // the read wait state lets a write in the previous data phase land first
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hresp     <= HRESP_OKAY[0];
         hreadyout <= !(accept && !hwrite);
         if (state == FE_READ) hrdata <= bus.hit ? bus.rdData : 32'h0000_0000;
      end
   end

endmodule

// ### rtl/gpfgh_ports.sv
// gpfgh_ports: configuration, data and pull-up registers of three pin ports and the
// pad multiplexing between software data and peripheral functions.
// assumes pad inputs and peripheral signals are synchronous to clk; pads are
// resolved outside from out/oe, pull-ups are switched by pullupEn.
`timescale 1ns/1ns

// Summary of operation
// [RULE1] Each first-port pin has a 2-bit selector for input, output or its external interrupt line; code three is reserved and reset is input.
// [RULE2] Each second-port pin has a 2-bit selector: input, output, or external interrupt lines eight to twenty-three in order, reset zero.
// [RULE3] Selector code three on chosen second-port pins picks timer clock, serial one flow control, sync serial one and select or panel power-down.
// [RULE4] Third-port selector code two picks the clock outputs, external uart clock, three serial channels and serial zero flow control, reset zero.
// [RULE5] On the third serial channel pins of the third port, code three carries serial one clear-to-send and request-to-send instead.
// [RULE6] Software sets first-port pins to interrupt mode before using them to wake from power-down.
// [RULE7] Software sets the lower eight second-port pins to interrupt mode before sleep if they wake the system.
// [RULE8] Software keeps the top three second-port pins as inputs when booting from NAND flash.
// [RULE9] A pin set as input reads back its current pad level in the data register.
// [RULE10] A pin set as output is driven with its data register bit.
// [RULE11] A pin given to an alternate function reads back an unspecified value from its data bit.
// [RULE12] A pull-up disable bit of zero enables the pin's pull-up and one switches it off.
// [RULE13] The first and third port pull-up disable registers reset to zero, all pull-ups on.
// [RULE14] The second port pull-up disable register resets with its upper six bits set.
// [RULE15] Port data registers are not reset and are undefined until written.
// [RULE16] Software does not write reserved selector codes; such pins behave as inputs.
// [RULE17] A register write changes pin direction, function, level and pull-up at the edge that ends the write; peripheral inputs change one edge later.
module gpfgh_ports
   import gpfgh_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              resetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic      [31:0]       hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // first port pads
   input  wire logic [F_W-1:0]    fPadIn,
   output logic      [F_W-1:0]    fPadOut,
   output logic      [F_W-1:0]    fPadOe,
   output logic      [F_W-1:0]    fPullupEn,
   // second port pads
   input  wire logic [G_W-1:0]    gPadIn,
   output logic      [G_W-1:0]    gPadOut,
   output logic      [G_W-1:0]    gPadOe,
   output logic      [G_W-1:0]    gPullupEn,
   // third port pads
   input  wire logic [H_W-1:0]    hPadIn,
   output logic      [H_W-1:0]    hPadOut,
   output logic      [H_W-1:0]    hPadOe,
   output logic      [H_W-1:0]    hPullupEn,
   // peripheral side
   output logic      [23:0]       extIntLine,
   input  wire logic [G_W-1:0]    gFuncOut,
   input  wire logic [G_W-1:0]    gFuncOe,
   output logic      [G_W-1:0]    gFuncIn,
   input  wire logic [H_W-1:0]    hFuncOut,
   input  wire logic [H_W-1:0]    hFuncOe,
   output logic      [H_W-1:0]    hFuncIn
);

   gpfgh_regs_if bus ();

   gpfgh_ahb_front u_front (
      .clk       (clk),
      .resetn    (resetn),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .bus       (bus)
   );

   // software registers
   logic [2*F_W-1:0] fCfg;
   logic [2*G_W-1:0] gCfg;
   logic [2*H_W-1:0] hCfg;
   logic [F_W-1:0]   fDat;
   logic [G_W-1:0]   gDat;
   logic [H_W-1:0]   hDat;
   logic [F_W-1:0]   fPud;
   logic [G_W-1:0]   gPud;
   logic [H_W-1:0]   hPud;

   // write decode
   wire wrFCfg = bus.wrEn && (bus.addr == ADDR_F_CFG);
   wire wrFDat = bus.wrEn && (bus.addr == ADDR_F_DAT);
   wire wrFPud = bus.wrEn && (bus.addr == ADDR_F_PUD);
   wire wrGCfg = bus.wrEn && (bus.addr == ADDR_G_CFG);
   wire wrGDat = bus.wrEn && (bus.addr == ADDR_G_DAT);
   wire wrGPud = bus.wrEn && (bus.addr == ADDR_G_PUD);
   wire wrHCfg = bus.wrEn && (bus.addr == ADDR_H_CFG);
   wire wrHDat = bus.wrEn && (bus.addr == ADDR_H_DAT);
   wire wrHPud = bus.wrEn && (bus.addr == ADDR_H_PUD);

   // next register values; pads are computed from these so a write shows at its own edge
   wire [2*F_W-1:0] next_fCfg = wrFCfg ? bus.wrData[2*F_W-1:0] : fCfg;   // [RULE1]
   wire [2*G_W-1:0] next_gCfg = wrGCfg ? bus.wrData[2*G_W-1:0] : gCfg;   // [RULE2]
   wire [2*H_W-1:0] next_hCfg = wrHCfg ? bus.wrData[2*H_W-1:0] : hCfg;   // [RULE4]
   wire [F_W-1:0]   next_fDat = wrFDat ? bus.wrData[F_W-1:0] : fDat;
   wire [G_W-1:0]   next_gDat = wrGDat ? bus.wrData[G_W-1:0] : gDat;
   wire [H_W-1:0]   next_hDat = wrHDat ? bus.wrData[H_W-1:0] : hDat;
   wire [F_W-1:0]   next_fPud = wrFPud ? bus.wrData[F_W-1:0] : fPud;
   wire [G_W-1:0]   next_gPud = wrGPud ? bus.wrData[G_W-1:0] : gPud;
   wire [H_W-1:0]   next_hPud = wrHPud ? bus.wrData[H_W-1:0] : hPud;

   // selector and pull-up registers carry reset values
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fCfg <= F_CFG_RST;                       // [RULE1]
         gCfg <= G_CFG_RST;                       // [RULE2]
         hCfg <= H_CFG_RST;                       // [RULE4]
         fPud <= F_PUD_RST;                       // [RULE13]
         gPud <= G_PUD_RST;                       // [RULE14]
         hPud <= H_PUD_RST;                       // [RULE13]
      end else begin
         fCfg <= next_fCfg;
         gCfg <= next_gCfg;
         hCfg <= next_hCfg;
         fPud <= next_fPud;
         gPud <= next_gPud;
         hPud <= next_hPud;
      end
   end

   // data registers have no reset: saves the reset net on 35 flops, content undefined
   always_ff @(posedge clk) begin
      fDat <= next_fDat;                          // [RULE15]
      gDat <= next_gDat;
      hDat <= next_hDat;
   end

   // combinational pad drive, read-back and peripheral inputs
   logic [F_W-1:0] fOutN;
   logic [F_W-1:0] fOeN;
   logic [F_W-1:0] fRd;
   logic [F_W-1:0] fEint;
   logic [G_W-1:0] gOutN;
   logic [G_W-1:0] gOeN;
   logic [G_W-1:0] gRd;
   logic [G_W-1:0] gEint;
   logic [G_W-1:0] gFnIn;
   logic [H_W-1:0] hOutN;
   logic [H_W-1:0] hOeN;
   logic [H_W-1:0] hRd;
   logic [H_W-1:0] hFnIn;

   // first port: code two hands the pad to the interrupt line, nothing is driven
   for (genvar i = 0; i < F_W; i++) begin : g_fpin
      wire [1:0] selN = next_fCfg[2*i +: 2];
      wire [1:0] sel  = fCfg[2*i +: 2];
      wire [1:0] drv  = pinDrive(selN, next_fDat[i], 1'b0, 1'b0, 1'b0, 1'b0, 1'b0); // [RULE10] [RULE16]
      assign fOutN[i] = drv[0];
      assign fOeN[i]  = drv[1];
      assign fRd[i]   = pinRead(sel, 1'b0, fPadIn[i], fDat[i]);                      // [RULE9] [RULE11]
      assign fEint[i] = (sel == SEL_ALT2) && fPadIn[i];                              // [RULE1] [RULE6]
   end

   // second port: code two feeds lines 8..23, code three goes to the mapped peripherals
   for (genvar i = 0; i < G_W; i++) begin : g_gpin
      wire [1:0] selN = next_gCfg[2*i +: 2];
      wire [1:0] sel  = gCfg[2*i +: 2];
      wire [1:0] drv  = pinDrive(selN, next_gDat[i], 1'b0, 1'b0,
                                 G_ALT3_MASK[i], gFuncOut[i], gFuncOe[i]);           // [RULE3] [RULE10]
      assign gOutN[i] = drv[0];
      assign gOeN[i]  = drv[1];
      assign gRd[i]   = pinRead(sel, G_ALT3_MASK[i], gPadIn[i], gDat[i]);           // [RULE9] [RULE11]
      assign gEint[i] = (sel == SEL_ALT2) && gPadIn[i];                              // [RULE2] [RULE7]
      assign gFnIn[i] = (sel == SEL_ALT3 && G_ALT3_MASK[i]) ? gPadIn[i] : 1'b1;      // [RULE3]
   end

   // third port: code two is the fixed function, code three only on the serial two pins
   for (genvar i = 0; i < H_W; i++) begin : g_hpin
      wire [1:0] selN = next_hCfg[2*i +: 2];
      wire [1:0] sel  = hCfg[2*i +: 2];
      // the serial one request line is shared with its second-port source
      wire a3o = (i == H_RTS_PIN) ? gFuncOut[G_RTS_PIN] : 1'b0;
      wire a3e = (i == H_RTS_PIN) ? gFuncOe[G_RTS_PIN] : 1'b0;
      wire [1:0] drv  = pinDrive(selN, next_hDat[i], hFuncOut[i], hFuncOe[i],
                                 H_ALT3_MASK[i], a3o, a3e);                          // [RULE4] [RULE5]
      assign hOutN[i] = drv[0];
      assign hOeN[i]  = drv[1];
      assign hRd[i]   = pinRead(sel, H_ALT3_MASK[i], hPadIn[i], hDat[i]);           // [RULE9] [RULE11]
      assign hFnIn[i] = (sel == SEL_ALT2) ? hPadIn[i] : 1'b1;                        // [RULE4]
   end

   // serial one clear-to-send: second-port pin wins if both are selected
   wire gCtsSel  = (gCfg[2*G_CTS_PIN +: 2] == SEL_ALT3);
   wire hCtsSel  = (hCfg[2*H_CTS_PIN +: 2] == SEL_ALT3);
   wire ctsLevel = gCtsSel ? gPadIn[G_CTS_PIN] : (hCtsSel ? hPadIn[H_CTS_PIN] : 1'b1); // [RULE5]

   wire [G_W-1:0] gFnInAll = {gFnIn[G_W-1:G_CTS_PIN+1], ctsLevel, gFnIn[G_CTS_PIN-1:0]};

   // pad outputs are registered from next values; one edge from write to pad
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fPadOut   <= {F_W{1'b0}};
         fPadOe    <= {F_W{1'b0}};
         fPullupEn <= ~F_PUD_RST;                 // [RULE13]
         gPadOut   <= {G_W{1'b0}};
         gPadOe    <= {G_W{1'b0}};
         gPullupEn <= ~G_PUD_RST;                 // [RULE14]
         hPadOut   <= {H_W{1'b0}};
         hPadOe    <= {H_W{1'b0}};
         hPullupEn <= ~H_PUD_RST;                 // [RULE13]
      end else begin
         fPadOut   <= fOutN;                      // [RULE17]
         fPadOe    <= fOeN;
         fPullupEn <= ~next_fPud;                 // [RULE12]
         gPadOut   <= gOutN;
         gPadOe    <= gOeN;
         gPullupEn <= ~next_gPud;                 // [RULE12]
         hPadOut   <= hOutN;
         hPadOe    <= hOeN;
         hPullupEn <= ~next_hPud;                 // [RULE12]
      end
   end

   // peripheral-side inputs, registered so every output comes from a flop
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         extIntLine <= 24'h00_0000;
         gFuncIn    <= {G_W{1'b1}};
         hFuncIn    <= {H_W{1'b1}};
      end else begin
         extIntLine <= {gEint, fEint};            // [RULE2]
         gFuncIn    <= gFnInAll;
         hFuncIn    <= hFnIn;
      end
   end

   // read-back mux; unmapped addresses read zero
   wire selFCfg = (bus.addr == ADDR_F_CFG);
   wire selFDat = (bus.addr == ADDR_F_DAT);
   wire selFPud = (bus.addr == ADDR_F_PUD);
   wire selGCfg = (bus.addr == ADDR_G_CFG);
   wire selGDat = (bus.addr == ADDR_G_DAT);
   wire selGPud = (bus.addr == ADDR_G_PUD);
   wire selHCfg = (bus.addr == ADDR_H_CFG);
   wire selHDat = (bus.addr == ADDR_H_DAT);
   wire selHPud = (bus.addr == ADDR_H_PUD);

   assign bus.hit = selFCfg | selFDat | selFPud | selGCfg | selGDat | selGPud |
                    selHCfg | selHDat | selHPud;

   assign bus.rdData = ({32{selFCfg}} & {16'h0000, fCfg})
                     | ({32{selFDat}} & {24'h00_0000, fRd})
                     | ({32{selFPud}} & {24'h00_0000, fPud})
                     | ({32{selGCfg}} & gCfg)
                     | ({32{selGDat}} & {16'h0000, gRd})
                     | ({32{selGPud}} & {16'h0000, gPud})
                     | ({32{selHCfg}} & {10'h000, hCfg})
                     | ({32{selHDat}} & {21'h00_0000, hRd})
                     | ({32{selHPud}} & {21'h00_0000, hPud});

endmodule

// ### sim/gpfgh_pad_model.sv
// gpfgh_pad_model: board side of one pin port; resolves every pad from the module drive,
// a board driver and the pull-up. assumes the bench sets the board driver per pin.
`timescale 1ns/1ns
module gpfgh_pad_model #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic [W-1:0] padOut,
   input  wire logic [W-1:0] padOe,
   input  wire logic [W-1:0] pullupEn,
   input  wire logic [W-1:0] boardVal,
   input  wire logic [W-1:0] boardEn,
   output logic      [W-1:0] padIn
);
   logic [W-1:0] last = '0;
   // module drive wins, then the board, then the pull-up; a pin left floating flips
   // every cycle so a stale level is never taken for a real one
   assign padIn = (padOe & padOut) | (~padOe & boardEn & boardVal)
                | (~padOe & ~boardEn & pullupEn)
                | (~padOe & ~boardEn & ~pullupEn & ~last);
   always @(posedge clk) last <= padIn;
endmodule

// ### sim/gpfgh_ports_chk.sv
// gpfgh_ports_chk: bus and pad checks on the top ports of the pin multiplexer.
// assumes hready is tied to hreadyout and a single clock domain.
`timescale 1ns/1ns
module gpfgh_ports_chk
   import gpfgh_pkg::*;
(
   input wire logic             clk,
   input wire logic             resetn,
   input wire logic             hsel,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic [2:0]       hsize,
   input wire logic [31:0]      hwdata,
   input wire logic             hready,
   input wire logic             hreadyout,
   input wire logic [F_W-1:0]   fPadIn,
   input wire logic [F_W-1:0]   fPadOut,
   input wire logic [F_W-1:0]   fPadOe,
   input wire logic [F_W-1:0]   fPullupEn,
   input wire logic [G_W-1:0]   gPadIn,
   input wire logic [G_W-1:0]   gPullupEn,
   input wire logic [H_W-1:0]   hPullupEn,
   input wire logic [H_W-1:0]   hPadIn,
   input wire logic [23:0]      extIntLine,
   input wire logic [G_W-1:0]   gFuncIn,
   input wire logic [H_W-1:0]   hFuncIn
);
   logic           rdAcc, fCfgWr, fDatWr, fPudWr;
   logic [F_W-1:0] cfgOe;
   wire            acc    = hsel & htrans[1] & hready;
   wire            wordWr = acc & hwrite & (hsize == 3'h2);
   // remember the kind of transfer in its data phase; the write lands one edge later
   always_ff @(posedge clk or negedge resetn)
      if (!resetn) {rdAcc, fCfgWr, fDatWr, fPudWr} <= 4'h0;
      else {rdAcc, fCfgWr, fDatWr, fPudWr} <= {acc & !hwrite, wordWr & (haddr == ADDR_F_CFG),
                                               wordWr & (haddr == ADDR_F_DAT), wordWr & (haddr == ADDR_F_PUD)};
   // output enables that a first-port config word should give; reserved codes stay off
   always_comb
      for (int i = 0; i < F_W; i++)
         cfgOe[i] = hwdata[2*i +: 2] == SEL_OUT;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   a_pull_reset: assert property ($rose(resetn) |->
      fPullupEn == 8'hff && gPullupEn == 16'h03ff && hPullupEn == 11'h7ff) else $error("pull-up reset");
   a_fcfg_oe: assert property (fCfgWr |=> fPadOe == $past(cfgOe)) else $error("config oe");
   a_fdat_out: assert property (fDatWr |=>
      ((fPadOut ^ $past(hwdata[7:0])) & fPadOe) == 8'h00) else $error("pad out level");
   a_fpud_en: assert property (fPudWr |=> fPullupEn == ~$past(hwdata[7:0])) else $error("pull-up en");
   a_external_interrupt_line_first: assert property ((extIntLine[7:0] & ~$past(fPadIn)) == 8'h00) else $error("external_interrupt_line f");
   a_external_interrupt_line_second: assert property ((extIntLine[23:8] & ~$past(gPadIn)) == 16'h0000) else $error("external_interrupt_line g");
   a_hfunc_in: assert property ((~hFuncIn & $past(hPadIn)) == 11'h000) else $error("h func in");
   a_gfunc_in: assert property ((~gFuncIn & $past(gPadIn) & 16'hfbff) == 16'h0000) else $error("g func in");
   a_read_wait: assert property (rdAcc |-> !hreadyout ##1 hreadyout) else $error("read wait state");
   c_data_write: cover property (fDatWr);
   c_read: cover property (rdAcc);
   c_external_interrupt_line: cover property (extIntLine != 24'h0);
endmodule

bind gpfgh_ports gpfgh_ports_chk u_chk (
   .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .fPadIn(fPadIn),
   .fPadOut(fPadOut), .fPadOe(fPadOe), .fPullupEn(fPullupEn), .gPadIn(gPadIn), .gPullupEn(gPullupEn),
   .hPullupEn(hPullupEn), .hPadIn(hPadIn), .extIntLine(extIntLine), .gFuncIn(gFuncIn), .hFuncIn(hFuncIn));

// ### sim/gpfgh_ports_tb.sv
// gpfgh_ports_tb: self-checking bench for the three-port pin multiplexer.
// assumes one AHB-Lite master (this bench) and a board model on every port.
`timescale 1ns/1ns
module gpfgh_ports_tb import gpfgh_pkg::*;;
   typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e;} gpfgh_row_t;
   logic             clk, resetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0]      haddr, hwdata, hrdata;
   logic [1:0]       htrans;
   logic [2:0]       hsize;
   logic [F_W-1:0]   fPadIn, fPadOut, fPadOe, fPullupEn, fBv, fBe;
   logic [G_W-1:0]   gPadIn, gPadOut, gPadOe, gPullupEn, gBv, gBe, gFuncOut, gFuncOe, gFuncIn;
   logic [H_W-1:0]   hPadIn, hPadOut, hPadOe, hPullupEn, hBv, hBe, hFuncOut, hFuncOe, hFuncIn;
   logic [23:0]      extIntLine;
   int               err_total, compares;
   // write, then read back with unused upper bits cleared; last row is unmapped
   gpfgh_row_t rows[7] = '{'{ADDR_F_CFG, 32'hffffffff, 32'h0000ffff}, '{ADDR_G_CFG, 32'h12345678, 32'h12345678},
      '{ADDR_H_CFG, 32'hffffffff, 32'h003fffff}, '{ADDR_F_PUD, 32'hffffffff, 32'h000000ff},
      '{ADDR_G_PUD, 32'hffffffff, 32'h0000ffff}, '{ADDR_H_PUD, 32'hffffffff, 32'h000007ff},
      '{32'h5600005c, 32'hffffffff, 32'h00000000}};

   gpfgh_ports u_gpfgh_ports (
      .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .fPadIn(fPadIn), .fPadOut(fPadOut), .fPadOe(fPadOe), .fPullupEn(fPullupEn),
      .gPadIn(gPadIn), .gPadOut(gPadOut), .gPadOe(gPadOe), .gPullupEn(gPullupEn), .hPadIn(hPadIn),
      .hPadOut(hPadOut), .hPadOe(hPadOe), .hPullupEn(hPullupEn), .extIntLine(extIntLine),
      .gFuncOut(gFuncOut), .gFuncOe(gFuncOe), .gFuncIn(gFuncIn), .hFuncOut(hFuncOut),
      .hFuncOe(hFuncOe), .hFuncIn(hFuncIn));
   gpfgh_pad_model #(.W(F_W)) u_gpfgh_pad_model_f (.clk(clk), .padOut(fPadOut), .padOe(fPadOe),
      .pullupEn(fPullupEn), .boardVal(fBv), .boardEn(fBe), .padIn(fPadIn));
   gpfgh_pad_model #(.W(G_W)) u_gpfgh_pad_model_g (.clk(clk), .padOut(gPadOut), .padOe(gPadOe),
      .pullupEn(gPullupEn), .boardVal(gBv), .boardEn(gBe), .padIn(gPadIn));
   gpfgh_pad_model #(.W(H_W)) u_gpfgh_pad_model_h (.clk(clk), .padOut(hPadOut), .padOe(hPadOe),
      .pullupEn(hPullupEn), .boardVal(hBv), .boardEn(hBe), .padIn(hPadIn));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one single word transfer; every signal held until hready is seen high
   task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(a, 1'b1, d, q);
   endtask

   task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      xfer(a, 1'b0, 32'h0, q);
      chk(q, e);
      chk(32'(hresp), 32'(HRESP_OKAY));
   endtask

   // two edges let the pads and the one-cycle function inputs settle
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic end_of_test();
      if (err_total == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   initial begin
      resetn = 1'b0;
      hsize = 3'h2;
      {hsel, haddr, htrans, hwrite, hwdata} = '0;
      {fBv, fBe, gBv, gBe, hBv, hBe} = '0;
      {gFuncOut, gFuncOe, hFuncOut, hFuncOe} = '0;
      {err_total, compares} = '0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      chk(32'(gPullupEn), 32'h03ff);
      rdChk(ADDR_F_CFG, 32'h0);
      rdChk(ADDR_G_CFG, 32'h0);
      rdChk(ADDR_H_CFG, 32'h0);
      rdChk(ADDR_F_PUD, 32'h0);
      rdChk(ADDR_G_PUD, 32'hfc00);
      rdChk(ADDR_H_PUD, 32'h0);
      for (int i = 0; i < 7; i++) begin
         wr(rows[i].a, rows[i].d);
         rdChk(rows[i].a, rows[i].e);
      end
      settle();
      chk(32'(fPadOe), 32'h0);
      chk(32'(fPullupEn), 32'h0);
      // all outputs, then a read straight after the data write
      wr(ADDR_F_CFG, 32'h5555);
      wr(ADDR_F_DAT, 32'ha5);
      rdChk(ADDR_F_DAT, 32'ha5);
      chk(32'(fPadOe), 32'hff);
      chk(32'(fPadOut), 32'ha5);
      // inputs: low nibble driven by the board, high nibble left to the pull-ups
      wr(ADDR_F_CFG, 32'h0);
      wr(ADDR_F_PUD, 32'h0);
      fBe <= 8'h0f;
      fBv <= 8'h3c;
      settle();
      rdChk(ADDR_F_DAT, 32'hfc);
      fBe <= 8'hff;
      fBv <= 8'h96;
      wr(ADDR_F_CFG, 32'haaaa);
      gBe <= 16'hffff;
      gBv <= 16'h5a5a;
      wr(ADDR_G_CFG, 32'h02aaaaaa);
      settle();
      chk(32'(extIntLine[7:0]), 32'h96);
      chk(32'(extIntLine[23:8]), 32'h1a5a);
      // code three on the second port, top three pins kept as inputs
      gFuncOe <= 16'h00f0;
      gFuncOut <= 16'h0050;
      wr(ADDR_G_CFG, 32'h03ffffff);
      settle();
      chk(32'(gPadOe), 32'h00f0);
      chk(32'(gPadOut & gPadOe), 32'h0050);
      chk(32'(gFuncIn), 32'hfb5b);
      wr(ADDR_G_CFG, 32'h0);
      hBe <= 11'h7ff;
      hBv <= 11'h2d3;
      hFuncOe <= 11'h7f0;
      hFuncOut <= 11'h555;
      wr(ADDR_H_CFG, 32'h2aaaaa);
      settle();
      chk(32'(hPadOe), 32'h7f0);
      chk(32'(hPadOut & hPadOe), 32'h550);
      chk(32'(hFuncIn), 32'h553);
      // serial one flow control moved onto the third port
      gFuncOe <= 16'h0200;
      gFuncOut <= 16'h0200;
      hBv <= 11'h000;
      wr(ADDR_H_CFG, 32'hf000);
      settle();
      chk(32'(hPadOe), 32'h040);
      chk(32'(hPadOut & hPadOe), 32'h040);
      chk(32'(gFuncIn), 32'hfbff);
      end_of_test();
   end

   // the whole run takes well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      err_total++;
      end_of_test();
   end
endmodule
